// file: src/lcis_pkg.sv
// package of constants and types for the logic cell input select block
package lcis_pkg;

  // register map, byte addresses on the bus
  localparam logic [31:0] LCIS_SEL_OFF     = 32'h0000_0000; // data channel 1/2 select register

  // field layout of the select register
  localparam int          LCIS_CH1_LSB     = 0;              // channel one source field, bits 2..0
  localparam int          LCIS_CH2_LSB     = 4;              // channel two source field, bits 6..4
  localparam int          LCIS_FIELD_W     = 3;
  localparam int          LCIS_RSVD_LO     = 3;              // reads as zero
  localparam int          LCIS_RSVD_HI     = 7;              // reads as zero
  localparam logic [3:0]  LCIS_CH2_BASE    = 4'h4;           // channel two starts at bus entry 4

  // bus side and check aid values after reset, and the htrans transfer codes
  localparam logic        LCIS_READY_RST   = 1'b1;
  localparam logic        LCIS_RESP_OKAY   = 1'b0;
  localparam logic [7:0]  LCIS_RDATA_RST   = 8'h00;
  localparam logic        LCIS_LOADED_RST  = 1'b0;           // check aid: no write seen since reset
  localparam logic [1:0]  LCIS_HTRANS_NSEQ = 2'h2;
  localparam logic [1:0]  LCIS_HTRANS_SEQ  = 2'h3;

  // whole state of the block
  typedef struct packed {
    logic [15:0] bus_meta;  // first synchroniser stage
    logic [15:0] bus_sync;  // second synchroniser stage
    logic [2:0]  ch1_sel;   // not reset: kept across resets
    logic [2:0]  ch2_sel;   // not reset: kept across resets
    logic        sel_loaded; // a write has landed since the last reset
    logic        ch1;
    logic        ch2;
    logic        wr_pend;   // write data phase to the select register
    logic        hready;
    logic        hresp;
    logic [7:0]  rdata;
  } lcis_state_t;

endpackage

// file: src/lcis_top.sv
// select register for data channels one and two of a logic cell, on an ahb-lite slave port
//
// Design decisions made here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps

module lcis_top
  import lcis_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [15:0] cell_input_bus,
  output logic             data_channel_one,
  output logic             data_channel_two
);

  // pick one entry of the cell input bus
  function automatic logic lcis_pick(input logic [15:0] bus, input logic [3:0] idx);
    lcis_pick = bus[idx];
  endfunction

  // register image as software reads it, reserved bits forced low
  function automatic logic [7:0] lcis_image(input logic [2:0] c1, input logic [2:0] c2);
    logic [7:0] v;
    v = 8'h00;
    v[LCIS_CH1_LSB +: LCIS_FIELD_W] = c1;
    v[LCIS_CH2_LSB +: LCIS_FIELD_W] = c2;
    v[LCIS_RSVD_LO] = 1'b0;
    v[LCIS_RSVD_HI] = 1'b0;
    lcis_image = v;
  endfunction

  lcis_state_t st_q;
  lcis_state_t st_d;

  logic        addr_phase;
  logic        addr_hit;
  logic [2:0]  new_ch1;
  logic [2:0]  new_ch2;
  logic [3:0]  ch2_idx;

  // address phase qualification and decode; unmapped words read zero, writes are dropped
  assign addr_phase = hsel && hready && (htrans == LCIS_HTRANS_NSEQ || htrans == LCIS_HTRANS_SEQ);
  assign addr_hit   = (haddr[31:2] == LCIS_SEL_OFF[31:2]);

  // field values after a pending write lands, forwarded so a read right after a write sees it
  assign new_ch1 = st_q.wr_pend ? hwdata[LCIS_CH1_LSB +: LCIS_FIELD_W] : st_q.ch1_sel;
  assign new_ch2 = st_q.wr_pend ? hwdata[LCIS_CH2_LSB +: LCIS_FIELD_W] : st_q.ch2_sel;
  assign ch2_idx = {1'b0, st_q.ch2_sel} + LCIS_CH2_BASE;

  // next state of the whole block
  always_comb begin
    st_d = st_q;
    // cell inputs come from other domains: two flip-flops before any use
    st_d.bus_meta = cell_input_bus;
    st_d.bus_sync = st_q.bus_meta;
    // channel routes from the synchronised bus
    st_d.ch1 = lcis_pick(st_q.bus_sync, {1'b0, st_q.ch1_sel});
    st_d.ch2 = lcis_pick(st_q.bus_sync, ch2_idx);
    // data phase of a write takes hwdata into both fields; bits 7 and 3 are not stored
    if (st_q.wr_pend) begin
      st_d.ch1_sel = new_ch1;
      st_d.ch2_sel = new_ch2;
      // fields are known from here on, the checks may look at them
      st_d.sel_loaded = 1'b1;
    end
    // zero wait state, always okay
    st_d.hready  = LCIS_READY_RST;
    st_d.hresp   = LCIS_RESP_OKAY;
    st_d.wr_pend = addr_phase && hwrite && addr_hit;
    if (addr_phase && !hwrite && addr_hit) begin
      st_d.rdata = lcis_image(new_ch1, new_ch2);
    end else begin
      st_d.rdata = LCIS_RDATA_RST;
    end
    // reset clears the bus side and synchronisers, the select fields stay as they are
    if (!rst_n) begin
      st_d.bus_meta = 16'h0000;
      st_d.bus_sync = 16'h0000;
      st_d.ch1      = 1'b0;
      st_d.ch2      = 1'b0;
      st_d.wr_pend  = 1'b0;
      st_d.hready   = LCIS_READY_RST;
      st_d.hresp    = LCIS_RESP_OKAY;
      st_d.rdata    = LCIS_RDATA_RST;
      // the check aid forgets the fields; they themselves are kept
      st_d.sel_loaded = LCIS_LOADED_RST;
      st_d.ch1_sel  = st_q.ch1_sel;
      st_d.ch2_sel  = st_q.ch2_sel;
    end
  end

  // one register stage for all state; no power-on value on the select fields
  always_ff @(posedge mclk) begin
    st_q <= st_d;
  end

  // outputs straight from the state register
  assign hrdata           = {24'h00_0000, st_q.rdata};
  assign hreadyout        = st_q.hready;
  assign hresp            = st_q.hresp;
  assign data_channel_one = st_q.ch1;
  assign data_channel_two = st_q.ch2;

  // checks on the select register and the channel routes
  // reference windows of the synchronised bus, one per channel, so the expected
  // pick is worked out apart from the design's index arithmetic
  logic [7:0] ch1_window;
  logic [7:0] ch2_window;
  logic       exp_ch1;
  logic       exp_ch2;
  assign ch1_window = st_q.bus_sync[7:0];
  assign ch2_window = st_q.bus_sync[11:4];
  assign exp_ch1    = ch1_window[st_q.ch1_sel];
  assign exp_ch2    = ch2_window[st_q.ch2_sel];

  // all checks below run on mclk and, except fields_kept_a and reset_quiet_a, are off while reset is low
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // route checks other than channel_one_low_a wait for sel_loaded: the fields are unknown from power-up
  // until software writes them, and an unknown pick proves nothing
  sequence wr_req_s;
    addr_phase && hwrite && addr_hit;
  endsequence

  sequence rd_req_s;
    addr_phase && !hwrite && addr_hit;
  endsequence

  // read of the select register never shows bits 7 or 3
  reserved_read_zero_a: assert property (rd_req_s |=> (hrdata[7] == 1'b0 && hrdata[3] == 1'b0))
    else $error("reserved select bit read as one");

  // read returns the written fields in the following data phase
  read_back_value_a: assert property (rd_req_s |=> hrdata[7:0] == {1'b0, st_q.ch2_sel, 1'b0, st_q.ch1_sel})
    else $error("select read data does not match fields");

  // channel two carries bus entry code plus four one cycle later
  channel_two_route_a: assert property (st_q.sel_loaded |=> data_channel_two == $past(exp_ch2))
    else $error("data channel two not routed from entry code plus four");

  // channel two stays low when entries 4..11 are all low, whatever the others do
  channel_two_low_a: assert property (st_q.sel_loaded && ch2_window == 8'h00 |=> !data_channel_two)
    else $error("channel two picked an entry outside 4 to 11");

  // channel two goes high when entries 4..11 are all high, whatever the others do
  channel_two_high_a: assert property (st_q.sel_loaded && ch2_window == 8'hFF |=> data_channel_two)
    else $error("channel two picked an entry outside 4 to 11");

  // channel one stays low when entries 0..7 are all low
  channel_one_span_a: assert property (st_q.sel_loaded && ch1_window == 8'h00 |=> !data_channel_one)
    else $error("channel one picked an entry outside 0 to 7");

  // upper channel one codes route to entries 3..7
  channel_one_high_a: assert property (st_q.sel_loaded && st_q.ch1_sel >= 3'h3 |=> data_channel_one == $past(exp_ch1))
    else $error("data channel one wrong for codes three to seven");

  // lower channel one codes route to entries 0..2
  channel_one_low_a: assert property (st_q.ch1_sel < 3'h3 |=> data_channel_one == $past(exp_ch1))
    else $error("data channel one wrong for codes zero to two");

  // a write lands in both fields at the end of its data phase
  write_lands_a: assert property (wr_req_s ##1 1'b1 |=> (st_q.ch1_sel == $past(hwdata[2:0])
                                  && st_q.ch2_sel == $past(hwdata[6:4])))
    else $error("select write did not land");

  // select fields survive a reset untouched
  fields_kept_a: assert property (@(posedge mclk) disable iff (1'b0)
                                  (!rst_n && !st_q.wr_pend && st_q.sel_loaded)
                                  |=> $stable(st_q.ch1_sel) && $stable(st_q.ch2_sel))
    else $error("select field changed across reset");

  // slave answers a read at once with okay
  ready_okay_a: assert property (rd_req_s |=> hreadyout && !hresp)
    else $error("slave not ready or not okay");

  // the upper three bytes of read data are always zero
  upper_bits_zero_a: assert property (hrdata[31:8] == 24'h00_0000)
    else $error("upper read data bits not zero");

  // read data is zero outside a data phase of a select register read
  idle_read_zero_a: assert property (!(addr_phase && !hwrite && addr_hit) |=> hrdata == 32'h0000_0000)
    else $error("read data not zero outside a read data phase");

  // reset clears the bus side and the channel outputs at the next edge
  reset_quiet_a: assert property (@(posedge mclk) disable iff (1'b0)
                                  !rst_n |=> (hrdata == 32'h0000_0000 && hreadyout && !hresp
                                  && !data_channel_one && !data_channel_two))
    else $error("bus side or channels not cleared by reset");

  sequence stray_wr_s;
    addr_phase && hwrite && !addr_hit && st_q.sel_loaded;
  endsequence

  // a write to an unmapped word leaves both fields alone
  unmapped_write_drop_a: assert property (stray_wr_s ##1 !st_q.wr_pend
                                          |=> $stable(st_q.ch1_sel) && $stable(st_q.ch2_sel))
    else $error("unmapped write changed a select field");

  // the slave never stalls and never reports an error
  hready_stays_a: assert property (hreadyout && !hresp)
    else $error("slave stalled or answered with an error");

  // a landing write marks the fields as known
  write_sets_loaded_a: assert property (st_q.wr_pend |=> st_q.sel_loaded)
    else $error("landed write did not mark the fields known");

  // once known, the fields stay known until a reset
  loaded_kept_a: assert property (st_q.sel_loaded |=> st_q.sel_loaded)
    else $error("select fields lost their known mark without reset");

endmodule // lcis_top

// file: tb/tb.sv
// self-checking testbench for the logic cell input select block
`timescale 1ns/1ps

module tb
  import lcis_pkg::*;
;
  logic        mclk           = 1'b0;
  logic        rst_n          = 1'b0;
  logic        hsel           = 1'b0;
  logic [31:0] haddr          = 32'h0000_0000;
  logic [1:0]  htrans         = 2'h0;
  logic        hwrite         = 1'b0;
  logic [2:0]  hsize          = 3'h2;
  logic [31:0] hwdata         = 32'h0000_0000;
  logic [15:0] cell_input_bus = 16'h0000;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        data_channel_one;
  logic        data_channel_two;
  logic [31:0] r;
  int          n_fail         = 0;
  int          checks_done    = 0;

  lcis_top i_lcis_top (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cell_input_bus(cell_input_bus),
    .data_channel_one(data_channel_one), .data_channel_two(data_channel_two));

  // free running 100 MHz clock
  initial begin
    forever #5 mclk = ~mclk;
  end

  task cmp32(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t word got %h expected %h", $time, got, exp);
    end
  endtask

  task cmp1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t channel got %b expected %b", $time, got, exp);
    end
  endtask

  // wait for an edge at which hready is seen high
  task wait_rdy;
    do @(posedge mclk); while (hreadyout !== 1'b1);
  endtask

  // one single ahb-lite transfer, address phase then data phase
  task xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd);
    @(posedge mclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= LCIS_HTRANS_NSEQ;
    hwrite <= wr;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    cmp1(hresp, LCIS_RESP_OKAY);
  endtask

  // drive the input bus and look at both channels after the sync latency
  task probe(input logic [15:0] b, input logic e1, input logic e2);
    @(posedge mclk);
    cell_input_bus <= b;
    repeat (4) @(posedge mclk);
    cmp1(data_channel_one, e1);
    cmp1(data_channel_two, e2);
  endtask

  // reserved bits read zero, unmapped address reads zero and is not stored
  task t_regs;
    xfer(1'b1, LCIS_SEL_OFF, 32'hFFFF_FFFF, r);
    xfer(1'b0, LCIS_SEL_OFF, 32'h0000_0000, r);
    cmp32(r, 32'h0000_0077);
    xfer(1'b1, 32'h0000_0004, 32'h0000_0000, r);
    xfer(1'b0, 32'h0000_0004, 32'h0000_0000, r);
    cmp32(r, 32'h0000_0000);
    xfer(1'b0, LCIS_SEL_OFF, 32'h0000_0000, r);
    cmp32(r, 32'h0000_0077);
  endtask

  // every code of both fields routes its documented entry
  task t_map;
    for (int c = 0; c < 8; c++) begin
      xfer(1'b1, LCIS_SEL_OFF, {25'h0, 3'(c), 1'b0, 3'(c)}, r);
      probe(16'h0001 << c, 1'b1, 1'b0);
      probe(16'h0010 << c, 1'b0, 1'b1);
      probe(~(16'h0001 << c), 1'b0, 1'b1);
    end
  endtask

  // select fields survive a reset in mid-run
  task t_keep;
    xfer(1'b1, LCIS_SEL_OFF, 32'h0000_0052, r);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    xfer(1'b0, LCIS_SEL_OFF, 32'h0000_0000, r);
    cmp32(r, 32'h0000_0052);
    probe(16'h0204, 1'b1, 1'b1);
  endtask

  task results;
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    #200000;
    n_fail++;
    results();
  end

  // main sequence
  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs();
    t_map();
    t_keep();
    results();
  end
endmodule // tb
